// *** design/cgr_config_regs.sv ***
// Notes on behaviour
// (RL1) Group D source from two-bit select
// (RL2) Stop bit stops output when source 0001
// (RL3) Internal stop is stop bit OR global
// (RL4) Stop bits packed across two stop registers
// (RL5) Four-bit mode field per pin
// (RL6) Modes 0000/0001 are inputs, 1xxx unused
// (RL7) Modes 0010/0011 drive low/high
// (RL8) Modes 0100/0101 push-pull status, true/inverted
// (RL9) Mode 0110: status 0 low, 1 released
// (RL10) Mode 0111: status 0 released, 1 low
// (RL11) Pin levels readable in every mode
// (RL12) Follow select: register index, bit index
// (RL13) Follow select used only in 01xx modes
// (RL14) Unimplemented followed bit drives pin low
// (RL15) Pin state and PLL enables not followable
// (RL16) Slave address bits 6:0, bit 7 zero
// (RL17) Reset pin loads 11101 plus select pins
// (RL18) Hard/soft reset bits keep slave address
// (RL19) Host never writes slave address zero
// (RL20) Global stop stops all 0001-source outputs
// (RL21) Pin state bits show raw level
// (RL22) Input modes keep driver released
`timescale 1ns/1ps
`include "cgr_params.svh"

module cgr_config_regs #(
  parameter int NUM_OUT = 10,
  parameter int NUM_PIN = 4,
  parameter logic [255:0] STATUS_IMPL_MASK = {256{1'b1}},
  parameter logic [4:0] PLL_IE_IDX = 5'h1F
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port from the management interface
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Master control bits held elsewhere
  input wire logic HARD_RESET_BIT,
  input wire logic SOFT_RESET_BIT,
  input wire logic GLOBAL_STOP_BIT,
  input wire logic BYPASS_PATH_SELECT,
  // Stop source selection per output, four bits each
  input wire logic [4*NUM_OUT-1:0] STOP_SOURCE_SELECTION,
  // Interface select pins
  input wire logic IF_SEL_PIN_ONE,
  input wire logic IF_SEL_PIN_ZERO,
  // Status space from 0x40 upward
  input wire logic [255:0] STATUS_VEC,
  // General-purpose pins
  input wire logic [NUM_PIN-1:0] GPIO_IN,
  output logic [NUM_PIN-1:0] GPIO_OUT,
  output logic [NUM_PIN-1:0] GPIO_OE,
  output logic [NUM_PIN-1:0] GPIO_VALUE,
  // Group D source steering
  output logic GRP_D_SEL_INTEGER,
  output logic GRP_D_SEL_FRAC,
  output logic GRP_D_SEL_BYPASS,
  output logic GRP_D_SEL_PATH2,
  // Per-output stop controls
  output logic [NUM_OUT-1:0] OUTPUT_STOP,
  // Slave address for the serial bus
  output logic [6:0] SLAVE_ADDR
);

  // Time-zero check on sizes the map can hold
  // Other sizes would need a new register map, so they raise an error
  initial begin
    if (NUM_OUT != 10 || NUM_PIN != 4) begin
      $error("cgr_config_regs: map holds ten outputs and four pins");
    end
  end

  // Mode field of pin n out of the two mode registers
  // Pins zero and one sit in the first register, two and three in the second
  function automatic logic [3:0] pin_mode(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input int n);
    logic [15:0] all_modes;
    all_modes = {b, a};
    pin_mode = all_modes[4*n +: 4]; // RL5
  endfunction

  // Stop enable of output n from stop bits and its source code
  function automatic logic stop_of(input logic [9:0] stp,
                                   input logic glob,
                                   input logic [39:0] src,
                                   input int n);
    logic hit;
    hit = (src[4*n +: 4] == `CGR_STOP_SRC_BITS);
    stop_of = hit && (stp[n] || glob); // RL2 RL3 RL20
  endfunction

  // Control registers
  // Unused upper bits are never stored, so they always read back zero
  logic [7:0] mux_second_reg; // Group D select in bits 1:0
  logic [7:0] stop_low_reg; // Outputs eight..one
  logic [1:0] stop_high_reg; // Outputs ten and nine
  logic [7:0] mode_a_reg; // Pins one and zero
  logic [7:0] mode_b_reg; // Pins three and two
  logic [7:0] follow_reg [NUM_PIN]; // Follow selections
  logic [6:0] addr_reg; // Serial slave address

  // Pin and select pin synchronisers
  logic [NUM_PIN-1:0] gpio_s1_reg;
  logic [NUM_PIN-1:0] gpio_s2_reg;
  logic [1:0] ifsel_s1_reg;
  logic [1:0] ifsel_s2_reg;

  // Clear for everything except the slave address, the read data register and the synchronisers
  // The reset bits act like the pin here, but the address only sees the pin
  wire logic ctl_clr = !RESETN || HARD_RESET_BIT || SOFT_RESET_BIT;

  // Write strobes per register
  // Addresses are distinct, so at most one strobe is high in a cycle
  wire logic wr_mux = REG_WR && (REG_ADDR == `CGR_OFS_MUX_SECOND);
  wire logic wr_stop_lo = REG_WR && (REG_ADDR == `CGR_OFS_STOP_LOW);
  wire logic wr_stop_hi = REG_WR && (REG_ADDR == `CGR_OFS_STOP_HIGH);
  wire logic wr_mode_a = REG_WR && (REG_ADDR == `CGR_OFS_MODE_A);
  wire logic wr_mode_b = REG_WR && (REG_ADDR == `CGR_OFS_MODE_B);
  wire logic wr_addr = REG_WR && (REG_ADDR == `CGR_OFS_SLAVE_ADDR);

  // Group D select decoded
  wire logic [1:0] grp_d = mux_second_reg[`CGR_GRP_D_LSB +: 2];

  // Stop bits joined in output order, output one at bit 0
  wire logic [9:0] stop_bits = {stop_high_reg, stop_low_reg}; // RL4

  // Per-pin modes
  logic [3:0] mode_w [NUM_PIN];
  logic [NUM_PIN-1:0] invert_w;

  // Pin synchronisers, two stages before any use
  // The select pins need two edges to settle, so the reset pin must be
  // held at least three edges before the loaded address is right
  always_ff @(posedge CLK) begin
    gpio_s1_reg <= GPIO_IN;
    gpio_s2_reg <= gpio_s1_reg;
    ifsel_s1_reg <= {IF_SEL_PIN_ONE, IF_SEL_PIN_ZERO};
    ifsel_s2_reg <= ifsel_s1_reg;
  end

  // Mux register, the only group used here is D
  // Bits 7:6 are unused and stored as zero; groups E and F are kept
  // only so that software reads back what it wrote
  always_ff @(posedge CLK) begin
    if (ctl_clr) begin
      mux_second_reg <= `CGR_RST_BYTE;
    end else if (wr_mux) begin
      mux_second_reg <= {2'h0, REG_WDATA[5:0]};
    end
  end

  // Stop control registers
  always_ff @(posedge CLK) begin
    if (ctl_clr) begin
      stop_low_reg <= `CGR_RST_BYTE;
      stop_high_reg <= 2'h0;
    end else begin
      if (wr_stop_lo) begin
        stop_low_reg <= REG_WDATA; // RL4
      end
      if (wr_stop_hi) begin
        stop_high_reg <= REG_WDATA[1:0]; // RL4
      end
    end
  end

  // Pin mode registers
  always_ff @(posedge CLK) begin
    if (ctl_clr) begin
      mode_a_reg <= `CGR_RST_BYTE;
      mode_b_reg <= `CGR_RST_BYTE;
    end else begin
      if (wr_mode_a) begin
        mode_a_reg <= REG_WDATA; // RL5
      end
      if (wr_mode_b) begin
        mode_b_reg <= REG_WDATA; // RL5
      end
    end
  end

  // Follow select registers and mode extraction, one per pin
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
    // Address of this pin's follow register
    wire logic wr_fol = REG_WR &&
      (REG_ADDR == (`CGR_OFS_FOLLOW0 + 7'(p)));

    // Follow select holds register and bit index
    always_ff @(posedge CLK) begin
      if (ctl_clr) begin
        follow_reg[p] <= `CGR_RST_BYTE;
      end else if (wr_fol) begin
        follow_reg[p] <= REG_WDATA; // RL12
      end
    end

    // Mode and input inversion of this pin
    assign mode_w[p] = pin_mode(mode_a_reg, mode_b_reg, p);
    assign invert_w[p] = (mode_w[p] == cgr_pkg::CGR_PM_IN_INV); // RL6

    // Pin driver
    cgr_pin_drv #(
      .STATUS_W(256),
      .IMPL_MASK(STATUS_IMPL_MASK),
      .PLL_IE_IDX(PLL_IE_IDX)
    ) u_drv (
      .clk(CLK),
      .clr(ctl_clr),
      .mode(mode_w[p]),
      .follow_sel(follow_reg[p]),
      .status_vec(STATUS_VEC),
      .pin_out(GPIO_OUT[p]),
      .pin_oe(GPIO_OE[p])
    );
  end

  // Slave address: only the reset pin reloads it
  // A zero address is stored as written: keeping it out is up to the host
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      // Upper bits fixed, lower bits from select pins
      addr_reg <= {`CGR_RST_ADDR_UPPER, ifsel_s2_reg}; // RL17
    end else if (wr_addr) begin
      // Hard and soft reset bits do not touch it
      addr_reg <= REG_WDATA[6:0]; // RL18 RL16
    end
  end

  // Read mux, unmapped addresses read zero
  // The pin state byte comes through the synchronisers, two edges late
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    case (REG_ADDR)
      `CGR_OFS_MUX_SECOND: begin
        rd_next = mux_second_reg;
      end
      `CGR_OFS_STOP_LOW: begin
        rd_next = stop_low_reg;
      end
      `CGR_OFS_STOP_HIGH: begin
        rd_next = {6'h00, stop_high_reg};
      end
      `CGR_OFS_MODE_A: begin
        rd_next = mode_a_reg;
      end
      `CGR_OFS_MODE_B: begin
        rd_next = mode_b_reg;
      end
      `CGR_OFS_FOLLOW0: begin
        rd_next = follow_reg[0];
      end
      `CGR_OFS_FOLLOW1: begin
        rd_next = follow_reg[1];
      end
      `CGR_OFS_FOLLOW2: begin
        rd_next = follow_reg[2];
      end
      `CGR_OFS_FOLLOW3: begin
        rd_next = follow_reg[3];
      end
      `CGR_OFS_SLAVE_ADDR: begin
        // Top bit always reads zero
        rd_next = {1'b0, addr_reg}; // RL16
      end
      `CGR_OFS_PIN_STATE: begin
        // Raw synchronised pin levels, no inversion
        rd_next = {4'h0, gpio_s2_reg}; // RL11 RL21
      end
      default: begin
        rd_next = 8'h00;
      end
    endcase
  end

  // Read data register, loaded on a read strobe
  // It holds between reads, so the host may take it any time before the next
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_next;
    end
  end

  // Group D steering flops
  // Bypass is a live input: a change of it moves the steering one edge later
  // Code 10 leaves all four lines low, so no path reaches the group
  always_ff @(posedge CLK) begin
    if (ctl_clr) begin
      GRP_D_SEL_INTEGER <= 1'b0;
      GRP_D_SEL_FRAC <= 1'b0;
      GRP_D_SEL_BYPASS <= 1'b0;
      GRP_D_SEL_PATH2 <= 1'b0;
    end else begin
      // Code 00 integer divider
      GRP_D_SEL_INTEGER <= (grp_d == cgr_pkg::CGR_SRC_INTEGER); // RL1
      // Code 01 fractional divider or bypass
      GRP_D_SEL_FRAC <= (grp_d == cgr_pkg::CGR_SRC_FRAC) &&
                        !BYPASS_PATH_SELECT; // RL1
      GRP_D_SEL_BYPASS <= (grp_d == cgr_pkg::CGR_SRC_FRAC) &&
                          BYPASS_PATH_SELECT; // RL1
      // Code 11 path two; code 10 selects nothing
      GRP_D_SEL_PATH2 <= (grp_d == cgr_pkg::CGR_SRC_PATH2); // RL1
    end
  end

  // Internal stop per output
  // Outputs with any other source code ignore both stop bits here;
  // their stop comes from a source outside this bank
  logic [NUM_OUT-1:0] stop_next;
  always_comb begin
    for (int n = 0; n < NUM_OUT; n++) begin
      stop_next[n] = stop_of(stop_bits, GLOBAL_STOP_BIT,
                             STOP_SOURCE_SELECTION, n); // RL2 RL3 RL20
    end
  end

  // Stop outputs and input values
  // Any of the three resets clears them, together with the control bits
  always_ff @(posedge CLK) begin
    if (ctl_clr) begin
      OUTPUT_STOP <= '0;
      GPIO_VALUE <= '0;
    end else begin
      OUTPUT_STOP <= stop_next;
      // Input value as software sees it, after optional inversion
      GPIO_VALUE <= gpio_s2_reg ^ invert_w; // RL6
    end
  end

  // Slave address output
  // One edge behind the register, so a write shows two edges after it
  always_ff @(posedge CLK) begin
    SLAVE_ADDR <= addr_reg; // RL16
  end

endmodule

// *** design/cgr_params.svh ***
`ifndef CGR_PARAMS_SVH
`define CGR_PARAMS_SVH

// Register offsets on the management port
`define CGR_OFS_MUX_SECOND 7'h08
`define CGR_OFS_STOP_LOW 7'h09
`define CGR_OFS_STOP_HIGH 7'h0A
`define CGR_OFS_MODE_A 7'h0B
`define CGR_OFS_MODE_B 7'h0C
`define CGR_OFS_FOLLOW0 7'h0D
`define CGR_OFS_FOLLOW1 7'h0E
`define CGR_OFS_FOLLOW2 7'h0F
`define CGR_OFS_FOLLOW3 7'h10
`define CGR_OFS_SLAVE_ADDR 7'h11
`define CGR_OFS_PIN_STATE 7'h41

// Reset values
`define CGR_RST_BYTE 8'h00
`define CGR_RST_ADDR_UPPER 5'h1D

// Field positions
`define CGR_GRP_D_LSB 0
`define CGR_FOLLOW_REG_LSB 3
`define CGR_FOLLOW_BIT_LSB 0

// Stop source code that hands control to the stop bits
`define CGR_STOP_SRC_BITS 4'h1

// Followed status space starts at this address
`define CGR_STATUS_BASE 8'h40
// Register indices excluded from following
`define CGR_IDX_PIN_STATE 5'h01

`endif

// *** design/cgr_pkg.sv ***
package cgr_pkg;

  // Four-bit pin mode field codes
  typedef enum logic [3:0] {
    CGR_PM_IN       = 4'h0,
    CGR_PM_IN_INV   = 4'h1,
    CGR_PM_DRV_LOW  = 4'h2,
    CGR_PM_DRV_HIGH = 4'h3,
    CGR_PM_ST_PP    = 4'h4,
    CGR_PM_ST_PP_N  = 4'h5,
    CGR_PM_ST_OD0   = 4'h6,
    CGR_PM_ST_OD1   = 4'h7
  } cgr_pin_mode_e;

  // Group D source select codes
  typedef enum logic [1:0] {
    CGR_SRC_INTEGER = 2'h0,
    CGR_SRC_FRAC    = 2'h1,
    CGR_SRC_UNUSED  = 2'h2,
    CGR_SRC_PATH2   = 2'h3
  } cgr_grp_src_e;

endpackage

// *** design/cgr_pin_drv.sv ***
`timescale 1ns/1ps
`include "cgr_params.svh"

// One general-purpose pin: decodes its mode and drives out and enable
module cgr_pin_drv #(
  parameter int STATUS_W = 256,
  parameter logic [255:0] IMPL_MASK = {256{1'b1}},
  parameter logic [4:0] PLL_IE_IDX = 5'h1F
) (
  // Clock and clear
  input wire logic clk,
  input wire logic clr,
  // Configuration
  input wire logic [3:0] mode,
  input wire logic [7:0] follow_sel,
  // Status space, bit index = register index * 8 + bit
  input wire logic [STATUS_W-1:0] status_vec,
  // Pin drive
  output logic pin_out,
  output logic pin_oe
);

  initial begin
    if (STATUS_W != 256) begin
      $error("cgr_pin_drv: status space must be 256 bits");
    end
  end

  // Register index part of the selection
  wire logic [4:0] reg_idx = follow_sel[7:`CGR_FOLLOW_REG_LSB];
  // Selected bit is real only if implemented and not excluded
  wire logic sel_ok = IMPL_MASK[follow_sel] && (reg_idx != `CGR_IDX_PIN_STATE)
                      && (reg_idx != PLL_IE_IDX); // RL15
  // Unimplemented selection follows a low level
  wire logic st_bit = sel_ok ? status_vec[follow_sel] : 1'b0; // RL14 RL12
  // Selection is used only in the 01xx modes
  wire logic is_status = (mode[3:2] == 2'b01); // RL13
  logic out_next;
  logic oe_next;

  // Mode decode
  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b0;
    case (mode)
      cgr_pkg::CGR_PM_DRV_LOW: begin
        oe_next = 1'b1; // RL7
      end
      cgr_pkg::CGR_PM_DRV_HIGH: begin
        out_next = 1'b1; // RL7
        oe_next = 1'b1;
      end
      cgr_pkg::CGR_PM_ST_PP: begin
        out_next = st_bit; // RL8
        oe_next = is_status;
      end
      cgr_pkg::CGR_PM_ST_PP_N: begin
        out_next = ~st_bit; // RL8
        oe_next = is_status;
      end
      cgr_pkg::CGR_PM_ST_OD0: begin
        oe_next = ~st_bit; // RL9
      end
      cgr_pkg::CGR_PM_ST_OD1: begin
        oe_next = st_bit; // RL10
      end
      default: begin
        // Input modes and unused codes keep the driver off
        oe_next = 1'b0; // RL22 RL6
      end
    endcase
    // A status mode with no real bit selected pulls the pin low in every variant
    if (is_status && !sel_ok) begin
      out_next = 1'b0; // RL14
      oe_next = 1'b1;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (clr) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= out_next;
      pin_oe <= oe_next;
    end
  end

endmodule

// *** tb/cgr_regs_checker.sv ***
`timescale 1ns/1ps
// Port-level checks of the config register bank
module cgr_regs_checker #(
  parameter int NUM_OUT = 10,
  parameter int NUM_PIN = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Control inputs
  input wire logic HARD_RESET_BIT,
  input wire logic SOFT_RESET_BIT,
  input wire logic GLOBAL_STOP_BIT,
  input wire logic [4*NUM_OUT-1:0] STOP_SOURCE_SELECTION,
  input wire logic IF_SEL_PIN_ONE,
  input wire logic IF_SEL_PIN_ZERO,
  // Pins and outputs
  input wire logic [NUM_PIN-1:0] GPIO_IN,
  input wire logic [NUM_PIN-1:0] GPIO_OUT,
  input wire logic [NUM_PIN-1:0] GPIO_OE,
  input wire logic GRP_D_SEL_INTEGER,
  input wire logic GRP_D_SEL_FRAC,
  input wire logic GRP_D_SEL_BYPASS,
  input wire logic GRP_D_SEL_PATH2,
  input wire logic [NUM_OUT-1:0] OUTPUT_STOP,
  input wire logic [6:0] SLAVE_ADDR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Clean write to one address with a data condition
  sequence s_wr(a, ok);
    REG_WR && REG_ADDR == a && ok && !HARD_RESET_BIT && !SOFT_RESET_BIT;
  endsequence
  // Neither reset bit set
  sequence s_quiet;
    !HARD_RESET_BIT && !SOFT_RESET_BIT;
  endsequence
  // Pins held for the synchroniser depth
  sequence s_pins_still;
    $stable(GPIO_IN)[*4];
  endsequence
  a_grp_onehot: assert property ($onehot0({GRP_D_SEL_INTEGER, GRP_D_SEL_FRAC,
    GRP_D_SEL_BYPASS, GRP_D_SEL_PATH2})) else $error("group D select not one-hot");
  a_grp_path2: assert property (s_wr(7'h08, REG_WDATA[1:0] == 2'h3) ##1 s_quiet
    |=> GRP_D_SEL_PATH2) else $error("path two not selected");
  a_stop_high: assert property (s_wr(7'h0A, REG_WDATA[1:0] == 2'h3 &&
    STOP_SOURCE_SELECTION[39:32] == 8'h11) ##1 s_quiet |=> OUTPUT_STOP[9:8] == 2'h3)
    else $error("upper stop bits not applied");
  a_global_stop: assert property ((GLOBAL_STOP_BIT && !HARD_RESET_BIT &&
    !SOFT_RESET_BIT && STOP_SOURCE_SELECTION[3:0] == 4'h1)[*3] |-> OUTPUT_STOP[0])
    else $error("global stop not applied");
  a_pin_low: assert property (s_wr(7'h0B, REG_WDATA[3:0] == 4'h2) ##1 s_quiet
    |=> GPIO_OE[0] && !GPIO_OUT[0]) else $error("pin not driven low");
  a_pin_release: assert property (s_wr(7'h0B, REG_WDATA[3:1] == 3'h0) ##1 s_quiet
    |=> !GPIO_OE[0]) else $error("input pin driven");
  a_pin_state: assert property (s_pins_still ##0 (REG_RD && REG_ADDR == 7'h41)
    |=> REG_RDATA[NUM_PIN-1:0] == $past(GPIO_IN)) else $error("pin state wrong");
  a_addr_reset: assert property ($rose(RESETN) |->
    SLAVE_ADDR == {5'h1D, IF_SEL_PIN_ONE, IF_SEL_PIN_ZERO}) else $error("bad reset address");
  a_addr_keep: assert property ((!(REG_WR && REG_ADDR == 7'h11))[*3]
    |=> $stable(SLAVE_ADDR)) else $error("address changed without write");
  a_addr_write: assert property (REG_WR && REG_ADDR == 7'h11
    |-> ##2 SLAVE_ADDR == $past(REG_WDATA[6:0], 2)) else $error("address write lost");
endmodule

bind cgr_config_regs cgr_regs_checker #(.NUM_OUT(NUM_OUT), .NUM_PIN(NUM_PIN)) u_chk (
  .CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .HARD_RESET_BIT(HARD_RESET_BIT), .SOFT_RESET_BIT(SOFT_RESET_BIT),
  .GLOBAL_STOP_BIT(GLOBAL_STOP_BIT), .STOP_SOURCE_SELECTION(STOP_SOURCE_SELECTION),
  .IF_SEL_PIN_ONE(IF_SEL_PIN_ONE), .IF_SEL_PIN_ZERO(IF_SEL_PIN_ZERO),
  .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
  .GRP_D_SEL_INTEGER(GRP_D_SEL_INTEGER), .GRP_D_SEL_FRAC(GRP_D_SEL_FRAC),
  .GRP_D_SEL_BYPASS(GRP_D_SEL_BYPASS), .GRP_D_SEL_PATH2(GRP_D_SEL_PATH2),
  .OUTPUT_STOP(OUTPUT_STOP), .SLAVE_ADDR(SLAVE_ADDR));

// *** tb/cgr_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register port, one transfer at a time
module cgr_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Write one byte; a zero slave address is never sent
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (!(a == 7'h11 && d[6:0] == 7'h00)) begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      reg_addr <= ~a;
    end
  endtask
  // Read one byte, answer sampled a cycle after the take
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// *** tb/tb_clock_gen_config_gpio_regs.sv ***
`timescale 1ns/1ps
// Bench for the config register bank
module tb_clock_gen_config_gpio_regs;
  logic clk, resetn, reg_wr, reg_rd, hard_bit, soft_bit, glob_stop, bypass, if_one, if_zero;
  logic [6:0] reg_addr, slave_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [39:0] stop_src;
  logic [255:0] status_vec;
  logic [3:0] pin_ext, gpio_in, gpio_out, gpio_oe, gpio_value;
  logic sel_int, sel_frac, sel_byp, sel_p2;
  logic [9:0] out_stop;
  int err_count = 0;
  int check_count = 0;
  // Wire level: driver wins, else the outside level
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_ext);
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Bit 29 of the status space left unimplemented
  cgr_config_regs #(.STATUS_IMPL_MASK(~(256'h1 << 29))) i_cgr_config_regs (
    .CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .HARD_RESET_BIT(hard_bit),
    .SOFT_RESET_BIT(soft_bit), .GLOBAL_STOP_BIT(glob_stop), .BYPASS_PATH_SELECT(bypass),
    .STOP_SOURCE_SELECTION(stop_src), .IF_SEL_PIN_ONE(if_one), .IF_SEL_PIN_ZERO(if_zero),
    .STATUS_VEC(status_vec), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe),
    .GPIO_VALUE(gpio_value), .GRP_D_SEL_INTEGER(sel_int), .GRP_D_SEL_FRAC(sel_frac),
    .GRP_D_SEL_BYPASS(sel_byp), .GRP_D_SEL_PATH2(sel_p2), .OUTPUT_STOP(out_stop),
    .SLAVE_ADDR(slave_addr));
  // Host on the register port
  cgr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Expected {enable, level} of a pin per mode and followed bit
  function automatic logic [1:0] pin_exp(input logic [3:0] m, input logic s);
    case (m)
      4'h2: return 2'b10;
      4'h3: return 2'b11;
      4'h4: return {1'b1, s};
      4'h5: return {1'b1, ~s};
      4'h6: return s ? 2'b00 : 2'b10;
      4'h7: return s ? 2'b10 : 2'b00;
      default: return 2'b00;
    endcase
  endfunction
  // Reset values of the bank from 0x09 to 0x10 and the slave address
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 9; a <= 16; a++) begin
      host.rd(a[6:0], d);
      chk(d, 8'h00);
    end
    host.rd(7'h11, d);
    chk(d, 8'h76);
    chk(slave_addr, 7'h76);
    $display("test reset done");
  endtask
  // Stop bits, their placement and the global stop
  task automatic t_stop();
    stop_src <= {10{4'h1}};
    host.wr(7'h09, 8'hA5);
    host.wr(7'h0A, 8'h03);
    idle(3);
    chk(out_stop, 10'h3A5);
    host.wr(7'h09, 8'h00);
    host.wr(7'h0A, 8'h00);
    glob_stop <= 1'b1;
    idle(3);
    chk(out_stop, 10'h3FF);
    stop_src <= {{9{4'h1}}, 4'h0};
    idle(3);
    chk(out_stop, 10'h3FE);
    glob_stop <= 1'b0;
    idle(3);
    chk(out_stop, 10'h000);
    $display("test stop done");
  endtask
  // Every group D code with both bypass settings
  task automatic t_grp();
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        bypass <= b[0];
        host.wr(7'h08, {6'h00, c[1:0]});
        idle(3);
        chk({sel_p2, sel_byp, sel_frac, sel_int}, {c == 3, c == 1 && b == 1,
          c == 1 && b == 0, c == 0});
      end
    end
    $display("test group done");
  endtask
  // All sixteen modes on every pin, followed bit low and high
  task automatic t_modes();
    for (int p = 0; p < 4; p++) begin
      host.wr(7'h0D + p[6:0], {5'h02, p[2:0]});
    end
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 16; m++) begin
        host.wr(7'h0B + p[7:1], p[0] ? {m[3:0], 4'h0} : {4'h0, m[3:0]});
        for (int s = 0; s < 2; s++) begin
          status_vec[16 + p] <= s[0];
          idle(4);
          chk({gpio_oe[p], gpio_oe[p] & gpio_out[p]}, pin_exp(m[3:0], s[0]));
        end
      end
    end
    $display("test modes done");
  endtask
  // Raw pin levels and the inverted input value
  task automatic t_state();
    logic [7:0] d;
    pin_ext <= 4'h1;
    host.wr(7'h0B, 8'h10);
    host.wr(7'h0C, 8'h32);
    idle(5);
    host.rd(7'h41, d);
    chk(d, 8'h09);
    chk(gpio_value, 4'hB);
    $display("test state done");
  endtask
  // Selections that must leave a status pin low, then one valid selection that follows its bit
  task automatic t_follow();
    logic [7:0] sel [4] = '{8'h08, 8'hFA, 8'h1D, 8'h1C};
    status_vec <= '1;
    for (int m = 4; m < 8; m++) begin
      host.wr(7'h0B, {4'h0, m[3:0]});
      for (int i = 0; i < 4; i++) begin
        host.wr(7'h0D, sel[i]);
        idle(3);
        chk({gpio_oe[0], gpio_out[0]}, i == 3 ? pin_exp(m[3:0], 1'b1) : 2'b10);
      end
    end
    $display("test follow done");
  endtask
  // Address write, then hard and soft reset bits
  task automatic t_resets();
    logic [7:0] d;
    host.wr(7'h11, 8'hA3);
    host.rd(7'h11, d);
    chk(d, 8'h23);
    for (int k = 0; k < 2; k++) begin
      host.wr(7'h09, 8'hFF);
      {hard_bit, soft_bit} <= k[0] ? 2'b01 : 2'b10;
      idle(3);
      {hard_bit, soft_bit} <= 2'b00;
      host.rd(7'h09, d);
      chk(d, 8'h00);
      chk(slave_addr, 7'h23);
    end
    resetn <= 1'b0;
    idle(4);
    resetn <= 1'b1;
    idle(2);
    chk(slave_addr, 7'h76);
    $display("test resets done");
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    {hard_bit, soft_bit, glob_stop, bypass} = 4'h0;
    {if_one, if_zero} = 2'b10;
    stop_src = '0;
    status_vec = '0;
    pin_ext = 4'hF;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_stop();
    t_grp();
    t_modes();
    t_state();
    t_follow();
    t_resets();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
